// ### inc/dtf_pkg.sv
// constants for the drive trip and fault handler
// assumes a single 50 MHz clock and synchronous inputs
package dtf_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // one second of clock cycles for the loss wait prescaler
    localparam int unsigned SEC_S = 1;
    localparam int unsigned TICKS_PER_SEC = SEC_S * CLK_HZ;
    // loss wait range in seconds
    localparam logic [6:0] WAIT_MIN_S = 7'h01;
    localparam logic [6:0] WAIT_MAX_S = 7'h78;
    // multi-function input width and external fault function code
    localparam int unsigned FUNC_W = 5;
    localparam logic [4:0] FUNC_EXT_FAULT = 5'h13;
    // loss reaction codes
    localparam logic [1:0] LOSS_CONTINUE = 2'h0;
    localparam logic [1:0] LOSS_COAST = 2'h1;
    localparam logic [1:0] LOSS_DECEL = 2'h2;
    localparam int unsigned NUM_INPUTS = 5;
endpackage : dtf_pkg

// ### src/dtf_loss_timer.sv
// loss wait timer for the frequency command
// assumes present_i and watch_i are synchronous to clk_i
`timescale 1ns/1ps
module dtf_loss_timer #(
    parameter int unsigned TICKS_PER_SEC = dtf_pkg::TICKS_PER_SEC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic watch_i,
    input wire logic present_i,
    input wire logic [6:0] wait_sec_i,
    output logic lost_o
);
    localparam int unsigned PW = $clog2(TICKS_PER_SEC);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICKS_PER_SEC - 1);

    // a prescaler shorter than two ticks cannot count a second
    if (TICKS_PER_SEC < 2) begin : g_bad_ticks
        $error("TICKS_PER_SEC must be at least 2");
    end

    logic [PW-1:0] pre_r, pre_nxt;
    logic [6:0] sec_r, sec_nxt;
    logic lost_r, lost_nxt;
    logic [6:0] wait_c;

    always_comb begin
        wait_c = wait_sec_i;
        if (wait_sec_i < dtf_pkg::WAIT_MIN_S) begin
            wait_c = dtf_pkg::WAIT_MIN_S;
        end else if (wait_sec_i > dtf_pkg::WAIT_MAX_S) begin
            wait_c = dtf_pkg::WAIT_MAX_S;
        end
        pre_nxt = pre_r;
        sec_nxt = sec_r;
        lost_nxt = lost_r;
        if (!watch_i || present_i) begin
            // any returning command restarts the wait
            pre_nxt = '0;
            sec_nxt = '0;
            lost_nxt = 1'b0;
        end else if (!lost_r) begin
            if (pre_r == PRE_LAST) begin
                pre_nxt = '0;
                sec_nxt = sec_r + 7'h01;
                if (sec_nxt >= wait_c) begin
                    lost_nxt = 1'b1; // see R10
                end
            end else begin
                pre_nxt = pre_r + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_r <= '0;
            sec_r <= '0;
            lost_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            sec_r <= sec_nxt;
            lost_r <= lost_nxt;
        end
    end

    assign lost_o = lost_r;

    lost_needs_absence_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R10
        $rose(lost_r) |-> $past(watch_i) && !$past(present_i))
        else $error("command declared lost while present");
    lost_after_wait_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R10
        $rose(lost_r) |-> sec_r >= $past(wait_c) && sec_r >= dtf_pkg::WAIT_MIN_S)
        else $error("command declared lost before the wait");
    sec_step_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R10
        sec_r != $past(sec_r) && sec_r != 7'h00 |-> $past(pre_r) == PRE_LAST)
        else $error("seconds counted before a full second");
endmodule : dtf_loss_timer

// ### src/dtf_trip_handler.sv
// trip and fault handling for a drive output stage
// assumes all inputs are synchronous to clk_i and already debounced
`timescale 1ns/1ps
// What this block does
// R01 - An active emergency stop cuts the output at once and flags an instant cut-off trip.
// R02 - Releasing the emergency stop while forward or reverse run is held resumes operation unprompted.
// R03 - An input set to code 19 as a normally-open external fault trips the output when its contact closes.
// R04 - An input set as a normally-closed external fault trips the output when its contact opens.
// R05 - Loss of an analog or serial frequency command triggers the selected loss reaction.
// R06 - A control circuit error raises the hardware fault indication.
// R07 - Failure to talk to the keypad raises the communication error indication.
// R08 - A cooling fan fault raises the fan fault indication.
// R09 - Loss reaction 0 keeps the last frequency, 1 cuts the output to coast, 2 decelerates to stop.
// R10 - The command counts as lost only after being absent for the wait time of 1 to 120 seconds.
// R11 - Every trip but the emergency stop stays latched with the output off until reset after its cause clears.
module dtf_trip_handler #(
    parameter int unsigned NUM_INPUTS = dtf_pkg::NUM_INPUTS,
    parameter int unsigned TICKS_PER_SEC = dtf_pkg::TICKS_PER_SEC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic estop_i,
    input wire logic forward_run_input_i,
    input wire logic reverse_run_input_i,
    input wire logic [NUM_INPUTS-1:0] multi_input_i,
    input wire logic [NUM_INPUTS*dtf_pkg::FUNC_W-1:0] multi_input_function_select_i,
    input wire logic [NUM_INPUTS-1:0] multi_input_nc_i,
    input wire logic remote_cmd_source_i,
    input wire logic cmd_present_i,
    input wire logic [1:0] loss_reaction_select_i,
    input wire logic [6:0] loss_wait_time_i,
    input wire logic ctrl_circuit_error_i,
    input wire logic keypad_link_fail_i,
    input wire logic fan_fault_i,
    input wire logic fault_reset_i,
    output logic output_enable_o,
    output logic estop_trip_o,
    output logic ext_fault_o,
    output logic hw_fault_o,
    output logic comm_fault_o,
    output logic fan_fault_o,
    output logic cmd_lost_o,
    output logic cmd_trip_o,
    output logic freq_hold_o,
    output logic decel_stop_o
);
    // refuse input counts outside the supported range
    if (NUM_INPUTS < 1 || NUM_INPUTS > 16) begin : g_bad_inputs
        $error("NUM_INPUTS must be 1 to 16");
    end

    logic [NUM_INPUTS-1:0] no_hit, nc_hit;
    logic ext_cause, run_req, lost_w;

    // per-input external fault decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
            logic is_ext;
            assign is_ext = multi_input_function_select_i[gi*dtf_pkg::FUNC_W +: dtf_pkg::FUNC_W]
                            == dtf_pkg::FUNC_EXT_FAULT;
            assign no_hit[gi] = is_ext && !multi_input_nc_i[gi] && multi_input_i[gi]; // see R03
            assign nc_hit[gi] = is_ext && multi_input_nc_i[gi] && !multi_input_i[gi]; // see R04
        end
    endgenerate

    assign ext_cause = |{no_hit, nc_hit};
    assign run_req = forward_run_input_i || reverse_run_input_i;

    dtf_loss_timer #(
        .TICKS_PER_SEC(TICKS_PER_SEC)
    ) u_loss (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .watch_i(remote_cmd_source_i),
        .present_i(cmd_present_i),
        .wait_sec_i(loss_wait_time_i),
        .lost_o(lost_w)
    );

    logic estop_r, estop_nxt;
    logic ext_r, ext_nxt;
    logic hw_r, hw_nxt;
    logic comm_r, comm_nxt;
    logic fan_r, fan_nxt;
    logic ctrip_r, ctrip_nxt;
    logic clear_ok;

    // trip flags: a setting cause always beats a reset in the same cycle
    always_comb begin
        clear_ok = fault_reset_i;
        if (estop_i) begin
            estop_nxt = 1'b1; // see R01
        end else if (run_req || fault_reset_i) begin
            estop_nxt = 1'b0; // see R02
        end else begin
            estop_nxt = estop_r;
        end
        ext_nxt = ext_cause || (ext_r && !clear_ok); // see R11
        hw_nxt = ctrl_circuit_error_i || (hw_r && !clear_ok); // see R06
        comm_nxt = keypad_link_fail_i || (comm_r && !clear_ok); // see R07
        fan_nxt = fan_fault_i || (fan_r && !clear_ok); // see R08
        // coast reaction, and any unassigned code, trips the output
        ctrip_nxt = (lost_w && loss_reaction_select_i != dtf_pkg::LOSS_CONTINUE
                     && loss_reaction_select_i != dtf_pkg::LOSS_DECEL)
                    || (ctrip_r && !(clear_ok && !lost_w)); // see R05 R09 R11
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            estop_r <= 1'b0;
            ext_r <= 1'b0;
            hw_r <= 1'b0;
            comm_r <= 1'b0;
            fan_r <= 1'b0;
            ctrip_r <= 1'b0;
        end else begin
            estop_r <= estop_nxt;
            ext_r <= ext_nxt;
            hw_r <= hw_nxt;
            comm_r <= comm_nxt;
            fan_r <= fan_nxt;
            ctrip_r <= ctrip_nxt;
        end
    end

    logic oe_r, oe_nxt;
    logic hold_r, hold_nxt;
    logic decel_r, decel_nxt;
    logic lost_r, lost_nxt;

    // output gate and loss reaction indications
    always_comb begin
        oe_nxt = run_req && !estop_i && !estop_nxt && !ext_nxt && !hw_nxt
                 && !comm_nxt && !fan_nxt && !ctrip_nxt; // see R01 R02 R11
        hold_nxt = lost_w && loss_reaction_select_i == dtf_pkg::LOSS_CONTINUE; // see R09
        decel_nxt = lost_w && loss_reaction_select_i == dtf_pkg::LOSS_DECEL; // see R09
        lost_nxt = lost_w; // see R05
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            oe_r <= 1'b0;
            hold_r <= 1'b0;
            decel_r <= 1'b0;
            lost_r <= 1'b0;
        end else begin
            oe_r <= oe_nxt;
            hold_r <= hold_nxt;
            decel_r <= decel_nxt;
            lost_r <= lost_nxt;
        end
    end

    assign output_enable_o = oe_r;
    assign estop_trip_o = estop_r;
    assign ext_fault_o = ext_r;
    assign hw_fault_o = hw_r;
    assign comm_fault_o = comm_r;
    assign fan_fault_o = fan_r;
    assign cmd_trip_o = ctrip_r;
    assign cmd_lost_o = lost_r;
    assign freq_hold_o = hold_r;
    assign decel_stop_o = decel_r;

    estop_cut_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R01
        estop_i |=> !output_enable_o && estop_trip_o)
        else $error("emergency stop did not cut the output");
    estop_resume_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R02
        estop_trip_o && !estop_i && forward_run_input_i && !ext_cause && !ctrl_circuit_error_i
        && !keypad_link_fail_i && !fan_fault_i && !lost_w && !ext_fault_o && !hw_fault_o
        && !comm_fault_o && !fan_fault_o && !cmd_trip_o |=> !estop_trip_o && output_enable_o)
        else $error("no resume after emergency stop release");
    ext_open_trip_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R03
        |no_hit |=> ext_fault_o && !output_enable_o)
        else $error("normally-open external fault missed");
    ext_closed_trip_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R04
        |nc_hit |=> ext_fault_o ##0 !output_enable_o)
        else $error("normally-closed external fault missed");
    loss_coast_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R05
        lost_w && loss_reaction_select_i == dtf_pkg::LOSS_COAST |=> cmd_trip_o && !output_enable_o)
        else $error("coast reaction did not cut the output");
    hw_fault_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R06
        ctrl_circuit_error_i |=> hw_fault_o && !output_enable_o)
        else $error("hardware fault not raised");
    comm_fault_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R07
        keypad_link_fail_i |=> comm_fault_o)
        else $error("keypad communication error not raised");
    fan_fault_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R08
        fan_fault_i |=> fan_fault_o)
        else $error("fan fault not raised");
    loss_modes_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R09
        lost_w |=> (freq_hold_o == ($past(loss_reaction_select_i) == dtf_pkg::LOSS_CONTINUE))
        && (decel_stop_o == ($past(loss_reaction_select_i) == dtf_pkg::LOSS_DECEL)))
        else $error("loss reaction indication wrong");
    trip_latch_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        ext_fault_o && !fault_reset_i |=> ext_fault_o && !output_enable_o)
        else $error("external fault released without reset");
    estop_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R02
        estop_trip_o && !estop_i && !forward_run_input_i && !reverse_run_input_i && !fault_reset_i
        |=> estop_trip_o)
        else $error("emergency stop trip released without a run input");
    run_gate_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R02
        !forward_run_input_i && !reverse_run_input_i |=> !output_enable_o)
        else $error("output enabled without a run input");
    ext_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        ext_fault_o && fault_reset_i && !ext_cause |=> !ext_fault_o)
        else $error("external fault not cleared by reset");
    hw_latch_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        hw_fault_o && !fault_reset_i |=> hw_fault_o && !output_enable_o)
        else $error("hardware fault released without reset");
    comm_latch_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        comm_fault_o && !fault_reset_i |=> comm_fault_o && !output_enable_o)
        else $error("communication error released without reset");
    fan_latch_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        fan_fault_o && !fault_reset_i |=> fan_fault_o && !output_enable_o)
        else $error("fan fault released without reset");
    coast_latch_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        cmd_trip_o && !fault_reset_i |=> cmd_trip_o && !output_enable_o)
        else $error("coast trip released without reset");
    lost_show_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R05
        lost_w |=> cmd_lost_o)
        else $error("command loss not shown");
    lost_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R05
        !lost_w |=> !cmd_lost_o)
        else $error("command loss shown while present");
endmodule : dtf_trip_handler

// ### testbench/dtf_cmd_source.sv
// frequency command source model standing on the far side of the drive
// assumes cut_i is driven just after the rising edge of clk_i
`timescale 1ns/1ps
module dtf_cmd_source #(
    parameter int unsigned LAG = 2
) (
    input wire logic clk_i,
    input wire logic cut_i,
    output logic cmd_present_o
);
    logic [LAG:0] pipe_r = '1;
    logic [LAG+1:0] pipe_nxt;
    // the command fades LAG+1 cycles after a cut request, so a slow source is modelled
    always_comb begin
        pipe_nxt = {pipe_r, ~cut_i};
    end
    always_ff @(posedge clk_i) begin
        pipe_r <= pipe_nxt[LAG:0];
    end
    assign cmd_present_o = pipe_r[LAG];
endmodule : dtf_cmd_source

// ### testbench/testbench.sv
// self-checking bench for the drive trip and fault handler
// assumes the design registers every output one cycle after the sampling edge
`timescale 1ns/1ps
module testbench;
    localparam int unsigned TPS = 4;
    localparam int unsigned LAG = 2;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic estop, fwd, rev, remote, cut, ctrl_err, kp_fail, fan, frst, present;
    logic [4:0] mi, nc;
    logic [24:0] fsel;
    logic [1:0] react;
    logic [6:0] wsec;
    logic oe, et, ef, hw, cm, ff, lost, ctrip, hold, dec;
    wire logic [2:0] flags = {hw, cm, ff};
    int err_count = 0;
    int checks_done = 0;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    dtf_cmd_source #(.LAG(LAG)) u_src (.clk_i(clk_i), .cut_i(cut), .cmd_present_o(present));
    dtf_trip_handler #(.TICKS_PER_SEC(TPS)) u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .estop_i(estop), .forward_run_input_i(fwd),
        .reverse_run_input_i(rev), .multi_input_i(mi), .multi_input_function_select_i(fsel),
        .multi_input_nc_i(nc), .remote_cmd_source_i(remote), .cmd_present_i(present),
        .loss_reaction_select_i(react), .loss_wait_time_i(wsec), .ctrl_circuit_error_i(ctrl_err),
        .keypad_link_fail_i(kp_fail), .fan_fault_i(fan), .fault_reset_i(frst),
        .output_enable_o(oe), .estop_trip_o(et), .ext_fault_o(ef), .hw_fault_o(hw),
        .comm_fault_o(cm), .fan_fault_o(ff), .cmd_lost_o(lost), .cmd_trip_o(ctrip),
        .freq_hold_o(hold), .decel_stop_o(dec));
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : step
    task automatic chk(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %b seen %b", name, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic clear_trip;
        frst = 1'b1;
        step(1);
        frst = 1'b0;
        step(1);
    endtask : clear_trip
    task automatic t_estop;
        logic fs, rs;
        fs = fwd;
        rs = rev;
        estop = 1'b1;
        step(1);
        chk("estop_trip", 1'b1, et);
        chk("oe_estop", 1'b0, oe);
        {fwd, rev} = 2'h0;
        estop = 1'b0;
        step(1);
        chk("estop_held", 1'b1, et);
        chk("oe_held", 1'b0, oe);
        fwd = fs;
        rev = rs;
        step(1);
        chk("estop_clear", 1'b0, et);
        chk("oe_resume", 1'b1, oe);
        $display("test estop done");
    endtask : t_estop
    task automatic t_ext(input logic nc_mode);
        fsel = 25'h13 << 10;
        nc = {2'h0, nc_mode, 2'h0};
        mi[2] = nc_mode;
        step(2);
        chk("ext_idle", 1'b0, ef);
        mi[2] = ~nc_mode;
        step(1);
        chk("ext_trip", 1'b1, ef);
        chk("oe_ext", 1'b0, oe);
        frst = 1'b1;
        step(1);
        chk("ext_cause_wins", 1'b1, ef);
        frst = 1'b0;
        mi[2] = nc_mode;
        step(2);
        chk("ext_latched", 1'b1, ef);
        clear_trip();
        chk("ext_cleared", 1'b0, ef);
        chk("oe_ext_back", 1'b1, oe);
        $display("test external fault done");
    endtask : t_ext
    task automatic t_cause(input int k);
        {ctrl_err, kp_fail, fan} = 3'h4 >> k;
        step(1);
        chk("cause_flag", 1'b1, flags[2-k]);
        chk("oe_cause", 1'b0, oe);
        {ctrl_err, kp_fail, fan} = 3'h0;
        step(2);
        chk("cause_latched", 1'b1, flags[2-k]);
        clear_trip();
        chk("cause_clear", 1'b0, flags[2-k]);
        $display("test cause %0d done", k);
    endtask : t_cause
    task automatic t_reset;
        reset_i = 1'b1;
        fan = 1'b1;
        step(2);
        chk("oe_mid_reset", 1'b0, oe);
        chk("fan_mid_reset", 1'b0, ff);
        fan = 1'b0;
        reset_i = 1'b0;
        step(2);
        chk("oe_after_reset", 1'b1, oe);
        $display("test mid-run reset done");
    endtask : t_reset
    task automatic t_local;
        remote = 1'b0;
        cut = 1'b1;
        step(LAG + 1 + TPS * 2 + 2);
        chk("local_not_lost", 1'b0, lost);
        chk("oe_local", 1'b1, oe);
        cut = 1'b0;
        step(LAG + 2);
        $display("test local command done");
    endtask : t_local
    task automatic t_loss(input logic [1:0] r, input logic [6:0] w);
        int n;
        int lim;
        logic coast;
        n = 0;
        lim = int'(w);
        if (w < dtf_pkg::WAIT_MIN_S) begin
            lim = int'(dtf_pkg::WAIT_MIN_S);
        end else if (w > dtf_pkg::WAIT_MAX_S) begin
            lim = int'(dtf_pkg::WAIT_MAX_S);
        end
        // source fade, the clamped wait in ticks, then the output register
        lim = LAG + 1 + TPS * lim + 1;
        coast = r == 2'h1 || r == 2'h3;
        react = r;
        wsec = w;
        remote = 1'b1;
        cut = 1'b1;
        while (lost !== 1'b1 && n < lim + 8) begin
            step(1);
            n++;
        end
        if (n >= lim + 8) begin
            $display("mismatch loss_wait expected %0d seen none", lim);
            err_count++;
            close_out();
        end
        checks_done++;
        if (n != lim) begin
            $display("mismatch loss_delay expected %0d seen %0d", lim, n);
            err_count++;
        end
        chk("hold", r == 2'h0, hold);
        chk("coast", coast, ctrip);
        chk("decel", r == 2'h2, dec);
        chk("oe_loss", !coast, oe);
        cut = 1'b0;
        remote = 1'b0;
        step(4);
        chk("loss_gone", 1'b0, lost);
        clear_trip();
        chk("coast_cleared", 1'b0, ctrip);
        $display("test loss reaction %0d done", r);
    endtask : t_loss
    initial begin
        {estop, rev, remote, cut, ctrl_err, kp_fail, fan, frst} = 8'h00;
        fwd = 1'b1;
        mi = 5'h00;
        nc = 5'h00;
        fsel = 25'h0;
        react = 2'h0;
        wsec = 7'h01;
        repeat (12) @(posedge clk_i);
        #2;
        chk("oe_in_reset", 1'b0, oe);
        reset_i = 1'b0;
        step(2);
        chk("oe_run", 1'b1, oe);
        t_estop();
        fwd = 1'b0;
        rev = 1'b1;
        t_estop();
        t_ext(1'b0);
        t_ext(1'b1);
        for (int k = 0; k < 3; k++) begin
            t_cause(k);
        end
        t_reset();
        t_local();
        t_loss(2'h0, 7'h01);
        t_loss(2'h1, 7'h00);
        t_loss(2'h2, 7'h02);
        t_loss(2'h3, 7'h7f);
        close_out();
    end
endmodule : testbench
